/* File: design/lcdpsc_pkg.sv */
// constants, command codes and carrier types for the lcd power-save and contrast control
// assumes commands arrive as whole bytes already qualified as instruction writes
package lcdpsc_pkg;

  // ****************************************************
  // command codes, main instruction table
  // ****************************************************
  localparam logic [7:0] LCDPSC_CMD_SUB_ENTER  = 8'h70;
  localparam logic [7:0] LCDPSC_CMD_RESET      = 8'he2;
  localparam logic [7:0] LCDPSC_CMD_DISP_OFF   = 8'hae;
  localparam logic [7:0] LCDPSC_CMD_DISP_ON    = 8'haf;
  localparam logic [7:0] LCDPSC_CMD_STATIC_OFF = 8'ha4;
  localparam logic [7:0] LCDPSC_CMD_STATIC_ON  = 8'ha5;
  localparam logic [7:0] LCDPSC_CMD_SEG_NORMAL = 8'ha0;
  localparam logic [7:0] LCDPSC_CMD_SEG_REVERS = 8'ha1;
  localparam logic [7:0] LCDPSC_CMD_PWR_OFF    = 8'h2e;
  localparam logic [7:0] LCDPSC_CMD_PWR_ON     = 8'h2f;
  localparam logic [7:0] LCDPSC_CMD_DRV_OFF    = 8'he4;
  localparam logic [7:0] LCDPSC_CMD_DRV_ON     = 8'he5;
  localparam logic [5:0] LCDPSC_CMD_BOOST_PFX  = 6'h0c;

  // ****************************************************
  // command codes, sub instruction table
  // ****************************************************
  localparam logic [7:0] LCDPSC_CMD_SUB_END    = 8'h71;
  localparam logic [3:0] LCDPSC_CMD_HI_PFX     = 4'h8;
  localparam logic [3:0] LCDPSC_CMD_LO_PFX     = 4'h9;
  localparam logic [7:0] LCDPSC_CMD_EXECUTE    = 8'ha0;

  // ****************************************************
  // reset values, contrast arithmetic and last segment index
  // ****************************************************
  localparam logic [7:0] LCDPSC_CONTRAST_RST   = 8'hff;
  localparam logic [1:0] LCDPSC_BOOST_RST      = 2'h3;
  localparam logic [8:0] LCDPSC_REF_OFFSET     = 9'h02d;
  localparam logic [8:0] LCDPSC_REF_SPAN       = 9'h12c;
  localparam logic [7:0] LCDPSC_LAST_SEG       = 8'h83;

  typedef struct packed {
    logic osc;
    logic booster;
    logic regulator;
    logic follower;
  } lcdpsc_supply_type;

  typedef enum logic [1:0] {
    LCDPSC_TBL_MAIN = 2'b01,
    LCDPSC_TBL_SUB  = 2'b10
  } lcdpsc_table_type;

endpackage : lcdpsc_pkg

/* File: design/lcdpsc_seg_map.sv */
// registered mapping of a display-memory column to its segment output number
// assumes the column index stays below the segment count
`timescale 1ns/10ps
module lcdpsc_seg_map
  import lcdpsc_pkg::*;
#(
  parameter int          W        = 8,
  parameter logic [7:0]  LAST_SEG = LCDPSC_LAST_SEG
) (
  input  wire logic         clk_sys_i,
  input  wire logic         nrst_i,
  input  wire logic         ce_i,
  input  wire logic         reverse_i,
  input  wire logic [W-1:0] col_i,
  output logic      [W-1:0] seg_o
);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      seg_o <= '0;
    end else if (ce_i) begin
      seg_o <= reverse_i ? W'(LAST_SEG[W-1:0] - col_i) : col_i;
    end
  end

endmodule : lcdpsc_seg_map

/* File: design/lcdpsc_ctrl.sv */
// power-save, drive gating, segment order and contrast code of the lcd driver
// assumes cmd_valid_i is a one-cycle strobe of an instruction byte, synchronous to clk_sys_i
`timescale 1ns/10ps

// Operation
// - driver command gates drive waveform on/off
// - display-off with static-on enters power-save
// - power-save stops oscillator and supply circuits
// - power-save forces outputs and bias to supply
// - power-save keeps memory and settings intact, except the driver-on flag
// - static-off leaves power-save at once
// - no waveform until driver-outputs-on executed
// - segment order flag reverses column mapping
// - booster runs only with a clock
// - contrast code is eight bits wide
// - reference fraction is code plus 45 over 300
// - two nibble writes, execute, then end
// - reset command loads contrast with all ones
module lcdpsc_ctrl
  import lcdpsc_pkg::*;
#(
  parameter int COL_W = 8
) (
  input  wire logic              clk_sys_i,
  input  wire logic              nrst_i,
  input  wire logic              ce_i,
  input  wire logic              cmd_valid_i,
  input  wire logic [7:0]        cmd_byte_i,
  input  wire logic              ext_clk_sel_i,
  input  wire logic [COL_W-1:0]  col_idx_i,
  output logic      [COL_W-1:0]  seg_idx_o,
  output logic                   drive_wave_o,
  output logic                   power_save_o,
  output lcdpsc_supply_type      supply_en_o,
  output logic                   outputs_to_vdd_o,
  output logic                   bias_to_vdd_o,
  output logic                   seg_reverse_o,
  output logic      [1:0]        boost_level_o,
  output logic      [7:0]        contrast_ladder_o,
  output logic      [8:0]        reference_level_o,
  output logic                   sub_mode_o
);

  // ****************************************************
  // command decode
  // ****************************************************
  lcdpsc_table_type tbl_q;
  logic             main_cmd;
  logic             sub_cmd;
  logic             disp_off_q;
  logic             static_on_q;
  logic             drv_on_q;
  logic             pwr_on_q;
  logic [3:0]       hi_q;
  logic [3:0]       lo_q;
  logic [7:0]       contrast_q;

  assign main_cmd = ce_i && cmd_valid_i && (tbl_q == LCDPSC_TBL_MAIN);
  assign sub_cmd  = ce_i && cmd_valid_i && (tbl_q == LCDPSC_TBL_SUB);

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tbl_q <= LCDPSC_TBL_MAIN;
    end else begin
      case (tbl_q)
        LCDPSC_TBL_MAIN: begin
          if (main_cmd && cmd_byte_i == LCDPSC_CMD_SUB_ENTER) begin
            tbl_q <= LCDPSC_TBL_SUB;
          end
        end
        LCDPSC_TBL_SUB: begin
          if (sub_cmd && cmd_byte_i == LCDPSC_CMD_SUB_END) begin
            tbl_q <= LCDPSC_TBL_MAIN;
          end
        end
        default: tbl_q <= LCDPSC_TBL_MAIN;
      endcase
    end
  end

  // ****************************************************
  // display, static drive and power-save
  // ****************************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      disp_off_q  <= 1'b1;
      static_on_q <= 1'b0;
    end else if (main_cmd) begin
      if (cmd_byte_i == LCDPSC_CMD_DISP_OFF) disp_off_q <= 1'b1;
      if (cmd_byte_i == LCDPSC_CMD_DISP_ON) disp_off_q <= 1'b0;
      if (cmd_byte_i == LCDPSC_CMD_STATIC_ON) static_on_q <= 1'b1;
      if (cmd_byte_i == LCDPSC_CMD_STATIC_OFF) static_on_q <= 1'b0;
    end
  end

  assign power_save_o = disp_off_q && static_on_q;

  // ****************************************************
  // driver outputs and internal supply
  // ****************************************************
  // drive flag drops inside power-save so release needs a fresh on command
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      drv_on_q <= 1'b0;
    end else if (ce_i) begin
      if (power_save_o) begin
        drv_on_q <= 1'b0;
      end else if (main_cmd && cmd_byte_i == LCDPSC_CMD_DRV_ON) begin
        drv_on_q <= 1'b1;
      end else if (main_cmd && cmd_byte_i == LCDPSC_CMD_DRV_OFF) begin
        drv_on_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwr_on_q      <= 1'b0;
      seg_reverse_o <= 1'b0;
      boost_level_o <= LCDPSC_BOOST_RST;
    end else if (main_cmd) begin
      if (cmd_byte_i == LCDPSC_CMD_PWR_ON) pwr_on_q <= 1'b1;
      if (cmd_byte_i == LCDPSC_CMD_PWR_OFF) pwr_on_q <= 1'b0;
      if (cmd_byte_i == LCDPSC_CMD_SEG_NORMAL) seg_reverse_o <= 1'b0;
      if (cmd_byte_i == LCDPSC_CMD_SEG_REVERS) seg_reverse_o <= 1'b1;
      if (cmd_byte_i[7:2] == LCDPSC_CMD_BOOST_PFX) boost_level_o <= cmd_byte_i[1:0];
      if (cmd_byte_i == LCDPSC_CMD_RESET) boost_level_o <= LCDPSC_BOOST_RST;
    end
  end

  // settings registers except drv_on_q are untouched by power-save; only the outputs are gated
  assign drive_wave_o          = drv_on_q && !power_save_o;
  assign supply_en_o.osc       = !power_save_o;
  assign supply_en_o.booster   = pwr_on_q && !power_save_o &&
                                 (supply_en_o.osc || ext_clk_sel_i);
  assign supply_en_o.regulator = pwr_on_q && !power_save_o;
  assign supply_en_o.follower  = pwr_on_q && !power_save_o;
  assign outputs_to_vdd_o      = power_save_o;
  assign bias_to_vdd_o         = power_save_o;
  assign sub_mode_o            = (tbl_q == LCDPSC_TBL_SUB);

  // ****************************************************
  // contrast code
  // ****************************************************
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hi_q <= LCDPSC_CONTRAST_RST[7:4];
      lo_q <= LCDPSC_CONTRAST_RST[3:0];
    end else if (sub_cmd) begin
      if (cmd_byte_i[7:4] == LCDPSC_CMD_HI_PFX) hi_q <= cmd_byte_i[3:0];
      if (cmd_byte_i[7:4] == LCDPSC_CMD_LO_PFX) lo_q <= cmd_byte_i[3:0];
    end
  end

  // staged nibbles only reach the ladder on execute, so half-written codes never show
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      contrast_q        <= LCDPSC_CONTRAST_RST;
      reference_level_o <= 9'(LCDPSC_CONTRAST_RST) + LCDPSC_REF_OFFSET;
    end else if (main_cmd && cmd_byte_i == LCDPSC_CMD_RESET) begin
      contrast_q        <= LCDPSC_CONTRAST_RST;
      reference_level_o <= 9'(LCDPSC_CONTRAST_RST) + LCDPSC_REF_OFFSET;
    end else if (sub_cmd && cmd_byte_i == LCDPSC_CMD_EXECUTE) begin
      contrast_q        <= {hi_q, lo_q};
      reference_level_o <= 9'({hi_q, lo_q}) + LCDPSC_REF_OFFSET;
    end
  end

  assign contrast_ladder_o = contrast_q;

  lcdpsc_seg_map #(
    .W        (COL_W),
    .LAST_SEG (LCDPSC_LAST_SEG)
  ) u_seg_map (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .ce_i      (ce_i),
    .reverse_i (seg_reverse_o),
    .col_i     (col_idx_i),
    .seg_o     (seg_idx_o)
  );

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  a_wave_gate_ps: assert property (power_save_o |-> !drive_wave_o && outputs_to_vdd_o)
    else $error("drive waveform present in power-save");
  a_ps_entry_cmd: assert property (main_cmd && cmd_byte_i == LCDPSC_CMD_STATIC_ON &&
      disp_off_q |=> power_save_o)
    else $error("power-save not entered after static on");
  a_ps_supplies_off: assert property (power_save_o |-> supply_en_o == '0)
    else $error("supply or oscillator running in power-save");
  a_ps_keeps_setting: assert property (power_save_o && !cmd_valid_i |=>
      $stable(contrast_q) && $stable(seg_reverse_o) && $stable(boost_level_o))
    else $error("settings changed during power-save");
  a_ps_exit_cmd: assert property (main_cmd && cmd_byte_i == LCDPSC_CMD_STATIC_OFF
      |=> !power_save_o)
    else $error("power-save not left after static off");
  a_drv_after_ps: assert property ($fell(power_save_o) |-> !drive_wave_o)
    else $error("waveform resumed without driver-outputs-on");
  a_drv_on_cmd: assert property (main_cmd && cmd_byte_i == LCDPSC_CMD_DRV_ON &&
      !power_save_o ##1 !power_save_o |-> drive_wave_o)
    else $error("driver-outputs-on not honoured");
  a_boost_clock: assert property (supply_en_o.booster |-> supply_en_o.osc || ext_clk_sel_i)
    else $error("booster enabled without clock");
  a_exec_load: assert property (sub_cmd && cmd_byte_i == LCDPSC_CMD_EXECUTE
      |=> contrast_q == $past({hi_q, lo_q}) ##1
      $stable(contrast_q) || $past(cmd_valid_i && ce_i))
    else $error("execute did not apply staged code");
  a_reset_cmd_ff: assert property (main_cmd && cmd_byte_i == LCDPSC_CMD_RESET
      |=> contrast_q == LCDPSC_CONTRAST_RST)
    else $error("reset command did not load all ones");
  a_ref_fraction: assert property (reference_level_o == 9'(contrast_q) + LCDPSC_REF_OFFSET &&
      reference_level_o <= LCDPSC_REF_SPAN)
    else $error("reference level out of step with contrast");
  a_contrast_hold: assert property (!(cmd_valid_i && ce_i) |=> $stable(contrast_q))
    else $error("contrast changed without command");

  c_ps_entry: cover property ($rose(power_save_o));
  c_ps_release: cover property ($fell(power_save_o) ##[1:20] drive_wave_o);
  c_exec_code: cover property (sub_cmd && cmd_byte_i == LCDPSC_CMD_EXECUTE);
  c_seg_reverse: cover property (seg_reverse_o && seg_idx_o == LCDPSC_LAST_SEG);

endmodule : lcdpsc_ctrl

/* File: tb/lcdpsc_host_model.sv */
// host side model that issues instruction bytes to the control block
// assumes one byte per strobe and one idle cycle between bytes
`timescale 1ns/10ps
module lcdpsc_host_model (
  input  wire logic       clk_sys_i,
  output logic            cmd_valid_o,
  output logic      [7:0] cmd_byte_o
);
  // ****************************************
  // instruction writes
  // ****************************************
  initial begin
    cmd_valid_o = 1'b0;
    cmd_byte_o  = 8'h00;
  end
  task automatic send(input logic [7:0] b);
    @(posedge clk_sys_i);
    #1 cmd_byte_o = b;
    cmd_valid_o = 1'b1;
    @(posedge clk_sys_i);
    #1 cmd_valid_o = 1'b0;
    // idle bus shows a changed value, never a stale command
    cmd_byte_o = ~cmd_byte_o;
  endtask : send
  task automatic set_contrast(input logic [7:0] c);
    send(8'h70);
    send({4'h8, c[7:4]});
    send({4'h9, c[3:0]});
    send(8'ha0);
    send(8'h71);
  endtask : set_contrast
endmodule : lcdpsc_host_model

/* File: tb/lcd_power_save_and_contrast_ctrl_test.sv */
// self-checking bench for power-save, drive gating, segment order and contrast
// assumes the host model is the only source of instruction bytes
`timescale 1ns/10ps
module lcd_power_save_and_contrast_ctrl_test;
  import lcdpsc_pkg::*;
  // ****************************************
  // bench infrastructure
  // ****************************************
  logic              clk_sys_i     = 1'b0;
  logic              nrst_i        = 1'b0;
  logic              ce_i;
  logic              ext_clk_sel_i;
  logic [7:0]        col_idx_i;
  logic              cmd_valid;
  logic [7:0]        cmd_byte;
  logic [7:0]        seg_idx_o;
  logic              drive_wave_o;
  logic              power_save_o;
  lcdpsc_supply_type supply_en_o;
  logic              outputs_to_vdd_o;
  logic              bias_to_vdd_o;
  logic              seg_reverse_o;
  logic [1:0]        boost_level_o;
  logic [7:0]        contrast_ladder_o;
  logic [8:0]        reference_level_o;
  logic              sub_mode_o;
  logic [7:0]        c;
  int                fail_count   = 0;
  int                total_checks = 0;
  always #2.5 clk_sys_i = ~clk_sys_i;
  lcdpsc_host_model host (
    .clk_sys_i   (clk_sys_i),
    .cmd_valid_o (cmd_valid),
    .cmd_byte_o  (cmd_byte)
  );
  lcdpsc_ctrl DUT (
    .clk_sys_i         (clk_sys_i),
    .nrst_i            (nrst_i),
    .ce_i              (ce_i),
    .cmd_valid_i       (cmd_valid),
    .cmd_byte_i        (cmd_byte),
    .ext_clk_sel_i     (ext_clk_sel_i),
    .col_idx_i         (col_idx_i),
    .seg_idx_o         (seg_idx_o),
    .drive_wave_o      (drive_wave_o),
    .power_save_o      (power_save_o),
    .supply_en_o       (supply_en_o),
    .outputs_to_vdd_o  (outputs_to_vdd_o),
    .bias_to_vdd_o     (bias_to_vdd_o),
    .seg_reverse_o     (seg_reverse_o),
    .boost_level_o     (boost_level_o),
    .contrast_ladder_o (contrast_ladder_o),
    .reference_level_o (reference_level_o),
    .sub_mode_o        (sub_mode_o)
  );
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  function automatic logic [8:0] exp_ref(input logic [7:0] code);
    return {1'b0, code} + 9'h02d;
  endfunction : exp_ref
  function automatic logic [7:0] exp_seg(input logic r, input logic [7:0] col);
    return r ? 8'h83 - col : col;
  endfunction : exp_seg
  task automatic final_report;
    if (fail_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  // about 210 cycles of traffic, so 40000 cycles means a hang
  initial begin
    #200000;
    fail_count++;
    final_report();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    ce_i          = 1'b1;
    ext_clk_sel_i = 1'b0;
    col_idx_i     = 8'h00;
    void'($urandom(82));
    repeat (10) @(posedge clk_sys_i);
    #1 nrst_i = 1'b1;
    chk("drive at reset", 9'h000, drive_wave_o);
    chk("supply at reset", 9'h008, supply_en_o);
    chk("contrast at reset", 9'h0ff, contrast_ladder_o);
    chk("reference at reset", 9'h12c, reference_level_o);
    host.send(8'h2f);
    host.send(8'he5);
    ext_clk_sel_i = 1'($urandom);
    chk("drive on", 9'h001, drive_wave_o);
    chk("supply on", 9'h00f, supply_en_o);
    chk("booster", 9'h001, supply_en_o.booster);
    host.send(8'he4);
    chk("drive off", 9'h000, drive_wave_o);
    for (int i = 0; i < 12; i++) begin
      c = (i == 0) ? 8'h4f : (i == 1) ? 8'h37 : 8'h37 + 8'($urandom_range(200));
      host.set_contrast(c);
      chk("contrast", {1'b0, c}, contrast_ladder_o);
      chk("reference", exp_ref(c), reference_level_o);
      chk("sub mode", 9'h000, sub_mode_o);
    end
    host.send(8'h70);
    chk("sub entered", 9'h001, sub_mode_o);
    host.send(8'he5);
    chk("main code in sub", 9'h000, drive_wave_o);
    host.send(8'h80);
    chk("staged only", {1'b0, c}, contrast_ladder_o);
    host.send(8'h71);
    host.send(8'h31);
    host.send(8'he2);
    chk("reset command", 9'h0ff, contrast_ladder_o);
    chk("reset boost", 9'h003, boost_level_o);
    for (int b = 0; b < 4; b++) begin
      host.send({6'h0c, 2'(3 - b)});
      chk("boost", 9'(3 - b), boost_level_o);
    end
    for (int r = 0; r < 2; r++) begin
      host.send(r[0] ? 8'ha1 : 8'ha0);
      chk("seg order", {8'h00, r[0]}, seg_reverse_o);
      for (int i = 0; i < 6; i++) begin
        @(posedge clk_sys_i);
        #1 col_idx_i = (i == 0) ? 8'h00 : (i == 1) ? 8'h83 : 8'($urandom_range(131));
        @(posedge clk_sys_i);
        #1 chk("segment", {1'b0, exp_seg(r[0], col_idx_i)}, seg_idx_o);
      end
    end
    host.send(8'he5);
    ext_clk_sel_i = 1'b1;
    host.send(8'ha5);
    chk("save entry", 9'h001, power_save_o);
    chk("save supplies", 9'h000, supply_en_o);
    chk("outputs to supply", 9'h001, outputs_to_vdd_o);
    chk("bias to supply", 9'h001, bias_to_vdd_o);
    chk("drive in save", 9'h000, drive_wave_o);
    chk("order kept", 9'h001, seg_reverse_o);
    chk("boost kept", 9'h000, boost_level_o);
    host.send(8'ha4);
    chk("save release", 9'h000, power_save_o);
    chk("osc back", 9'h001, supply_en_o.osc);
    chk("no drive yet", 9'h000, drive_wave_o);
    host.send(8'he5);
    chk("drive after on", 9'h001, drive_wave_o);
    host.send(8'haf);
    host.send(8'ha5);
    chk("static with display on", 9'h000, power_save_o);
    host.send(8'hae);
    chk("save reverse order", 9'h001, power_save_o);
    host.send(8'haf);
    chk("save cleared", 9'h000, power_save_o);
    host.send(8'ha4);
    ce_i = 1'b0;
    host.send(8'ha0);
    chk("ce low ignored", 9'h001, seg_reverse_o);
    ce_i = 1'b1;
    host.send(8'h2e);
    chk("supply off", 9'h008, supply_en_o);
    final_report();
  end
endmodule : lcd_power_save_and_contrast_ctrl_test
